// file: shared/pmea_map.vh
// constants of the power mode and eeprom arbiter block
`ifndef PMEA_MAP_VH
`define PMEA_MAP_VH
// eeprom word addresses of configuration and password
`define PMEA_ADDR_CFG   8'h04
`define PMEA_ADDR_PWD   8'h05
// configuration word fields
`define PMEA_F_PM       1:0
`define PMEA_F_WMASK    7:4
`define PMEA_F_VSEL     12:8
`define PMEA_F_RSEL     14:13
`define PMEA_B_SILENT   16
`define PMEA_B_RPROT    24
`define PMEA_B_WPROT    25
`define PMEA_F_ALIM     31:26
// power mode codes
`define PMEA_PM_DEF     2'h0
`define PMEA_PM_EXT     2'h3
// reset values
`define PMEA_CFG_RST    32'h0
`define PMEA_PWD_RST    32'h0
`define PMEA_PIN_RST    4'h4
// authentication attempt limit
`define PMEA_AUTH_MAX   3'h7
// harvest voltage table
`define PMEA_VSEL_TOP   5'h1a
`define PMEA_MV_BASE    13'h076c
`define PMEA_MV_STEP    13'h0064
`define PMEA_MV_OUT     13'h0708
// timing
`define PMEA_CLK_NS     10
`define PMEA_IODD_NS    450000
`endif

// file: hw/pmea_core.v
// power mode, start-up load, reset and eeprom arbitration logic
`timescale 1ns/100ps
`include "pmea_map.vh"
module pmea_core #(
   parameter AW       = 8,
   parameter DW       = 32,
   parameter HW       = 17,
   parameter IODD_CYC = (`PMEA_IODD_NS + `PMEA_CLK_NS - 1) / `PMEA_CLK_NS
) (
   // clock and reset
   input  wire          i_clk,
   input  wire          i_rst,
   // pins, asynchronous
   input  wire          i_field_power_on_detect,
   input  wire          i_io_supply_pin,
   input  wire          i_cs_n,
   input  wire          i_io_below_thr,
   // host power mode write
   input  wire          i_cfg2_wr,
   input  wire [1:0]    i_cfg2_mode,
   // rf engine requests
   input  wire          i_rf_req,
   input  wire          i_rf_we,
   input  wire [AW-1:0] i_rf_addr,
   input  wire [DW-1:0] i_rf_wdata,
   input  wire          i_ev_selected,
   input  wire          i_ev_sleep_req,
   // serial engine requests
   input  wire          i_sp_req,
   input  wire          i_sp_we,
   input  wire [AW-1:0] i_sp_addr,
   input  wire [DW-1:0] i_sp_wdata,
   // eeprom
   input  wire          i_ee_done,
   input  wire [DW-1:0] i_ee_rdata,
   output reg           o_ee_req,
   output reg           o_ee_we,
   output reg  [AW-1:0] o_ee_addr,
   output reg  [DW-1:0] o_ee_wdata,
   // rf answers
   output reg           o_rf_done,
   output reg           o_rf_nak_conflict,
   output reg           o_rf_nak_prot,
   output reg  [DW-1:0] o_rf_rdata,
   output reg           o_rf_off,
   // serial answers
   output reg           o_sp_done,
   output reg  [DW-1:0] o_sp_rdata,
   // host interrupts
   output reg           o_irq_init,
   output reg           o_irq_err_acc,
   output reg           o_irq_wake,
   // power and status
   output reg           o_ready,
   output reg           o_vdd_on,
   output reg           o_vdd_from_io,
   output reg  [1:0]    o_power_mode_setting,
   output reg           o_harvest_en,
   output reg           o_harvest_oe_n,
   output reg  [1:0]    o_harvest_rsel,
   output reg  [12:0]   o_harvest_mv,
   output reg           o_auth_ok,
   output reg           o_auth_locked
);

   // init states
   localparam [3:0] S_OFF  = 4'b0001;
   localparam [3:0] S_LCFG = 4'b0010;
   localparam [3:0] S_LPWD = 4'b0100;
   localparam [3:0] S_RUN  = 4'b1000;
   // arbiter owners
   localparam [2:0] A_IDLE = 3'b001;
   localparam [2:0] A_RF   = 3'b010;
   localparam [2:0] A_SP   = 3'b100;

   // pin synchronisers
   reg  [3:0]    pin_s1_ff;
   reg  [3:0]    pin_s2_ff;
   wire          field;
   wire          io_on;
   wire          cs_low;
   wire          io_low;

   // state
   reg  [3:0]    init_ff;
   reg  [2:0]    own_ff;
   reg           own_we_ff;
   reg  [AW-1:0] own_addr_ff;
   reg  [DW-1:0] own_wdata_ff;
   reg  [DW-1:0] cfg_ff;
   reg  [DW-1:0] pwd_ff;
   reg  [1:0]    pm_ff;
   reg  [HW-1:0] hold_ff;
   reg  [2:0]    fail_ff;
   reg           auth_ff;

   // combinational power decode
   reg           nxt_vdd_from_io;
   reg           nxt_powered;
   wire          pm_ext;
   wire          locked;
   wire          silent_block;
   wire          harv_on;

   assign field  = pin_s2_ff[0];
   assign io_on  = pin_s2_ff[1];
   assign cs_low = ~pin_s2_ff[2];
   assign io_low = pin_s2_ff[3];
   assign pm_ext = (pm_ff == `PMEA_PM_EXT);
   assign locked = (fail_ff == `PMEA_AUTH_MAX);

   // silent mode drops rf requests while io is below threshold
   assign silent_block = cfg_ff[`PMEA_B_SILENT] & io_low;

   // output enable only in default mode with a non-zero resistance
   assign harv_on = init_ff[3] & (pm_ff == `PMEA_PM_DEF)
                    & (cfg_ff[`PMEA_F_RSEL] != 2'h0);

   // voltage code to millivolts, codes above the top fall back to 1.8 v
   function [12:0] harv_mv;
      input [4:0] code;
      begin
         if (code <= `PMEA_VSEL_TOP) begin
            harv_mv = `PMEA_MV_BASE + `PMEA_MV_STEP * {8'h00, code};
         end else begin
            harv_mv = `PMEA_MV_OUT;
         end
      end
   endfunction

   // rf access guarded by password unless authenticated
   function prot_hit;
      input [AW-1:0] addr;
      input          we;
      begin
         prot_hit = ~auth_ff & (addr >= {{(AW-6){1'b0}}, cfg_ff[`PMEA_F_ALIM]})
                    & (we ? cfg_ff[`PMEA_B_WPROT] : cfg_ff[`PMEA_B_RPROT]);
      end
   endfunction

   // pins pass two flops; first stage feeds only the second
   always @(posedge i_clk) begin
      if (i_rst) begin
         pin_s1_ff <= `PMEA_PIN_RST;
         pin_s2_ff <= `PMEA_PIN_RST;
      end else begin
         pin_s1_ff <= {i_io_below_thr, i_cs_n, i_io_supply_pin, i_field_power_on_detect};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // io switch hold timer, reloaded while cs low or serial write busy
   always @(posedge i_clk) begin
      if (i_rst) begin
         hold_ff <= {HW{1'b0}};
      end else if (io_on & (cs_low | (own_ff[2] & own_we_ff))) begin
         hold_ff <= IODD_CYC[HW-1:0];
      end else if (hold_ff != {HW{1'b0}}) begin
         hold_ff <= hold_ff - {{(HW-1){1'b0}}, 1'b1};
      end
   end

   // supply selection
   always @* begin
      nxt_vdd_from_io = io_on & (pm_ext | (~field & (cs_low | (hold_ff != {HW{1'b0}}))));
      nxt_powered     = field | nxt_vdd_from_io;
   end

   // start-up load and full reset
   always @(posedge i_clk) begin
      if (i_rst) begin
         init_ff <= S_OFF;
         cfg_ff  <= `PMEA_CFG_RST;
         pwd_ff  <= `PMEA_PWD_RST;
         pm_ff   <= `PMEA_PM_DEF;
      end else begin
         case (init_ff)
            S_OFF: begin
               if (nxt_powered) begin
                  init_ff <= S_LCFG;
               end
            end
            S_LCFG: begin
               if (i_ee_done) begin
                  cfg_ff  <= i_ee_rdata;
                  pm_ff   <= i_ee_rdata[`PMEA_F_PM];
                  init_ff <= S_LPWD;
               end
            end
            S_LPWD: begin
               if (i_ee_done) begin
                  pwd_ff  <= i_ee_rdata;
                  init_ff <= S_RUN;
               end
            end
            S_RUN: begin
               if (~nxt_powered) begin
                  init_ff <= S_OFF;
                  pm_ff   <= `PMEA_PM_DEF;
               end else if (i_cfg2_wr & own_ff[0]) begin
                  pm_ff   <= i_cfg2_mode;
               end
               if (own_ff[1] & i_ee_done & own_we_ff & (own_addr_ff == `PMEA_ADDR_PWD)) begin
                  pwd_ff <= own_wdata_ff;
               end else if (own_ff[2] & i_ee_done & own_we_ff & (own_addr_ff == `PMEA_ADDR_PWD)) begin
                  pwd_ff <= own_wdata_ff;
               end
            end
            default: begin
               init_ff <= S_OFF;
            end
         endcase
      end
   end

   // arbiter; a lost power takes the grant with it
   always @(posedge i_clk) begin
      if (i_rst) begin
         own_ff            <= A_IDLE;
         own_we_ff         <= 1'b0;
         own_addr_ff       <= {AW{1'b0}};
         own_wdata_ff      <= {DW{1'b0}};
         o_ee_req          <= 1'b0;
         o_ee_we           <= 1'b0;
         o_ee_addr         <= {AW{1'b0}};
         o_ee_wdata        <= {DW{1'b0}};
         o_rf_done         <= 1'b0;
         o_rf_nak_conflict <= 1'b0;
         o_rf_nak_prot     <= 1'b0;
         o_rf_rdata        <= {DW{1'b0}};
         o_sp_done         <= 1'b0;
         o_sp_rdata        <= {DW{1'b0}};
         o_irq_init        <= 1'b0;
         o_irq_err_acc     <= 1'b0;
         o_irq_wake        <= 1'b0;
         fail_ff           <= 3'h0;
         auth_ff           <= 1'b0;
      end else begin
         o_ee_req          <= 1'b0;
         o_rf_done         <= 1'b0;
         o_rf_nak_conflict <= 1'b0;
         o_rf_nak_prot     <= 1'b0;
         o_sp_done         <= 1'b0;
         o_irq_init        <= 1'b0;
         o_irq_err_acc     <= 1'b0;
         o_irq_wake        <= |(cfg_ff[`PMEA_F_WMASK] & {own_ff[1] & i_ee_done & own_we_ff,
                              i_ev_sleep_req, i_ev_selected,
                              init_ff[2] & i_ee_done});
         if (init_ff[0] & nxt_powered) begin
            o_ee_req  <= 1'b1;
            o_ee_we   <= 1'b0;
            o_ee_addr <= `PMEA_ADDR_CFG;
         end else if (init_ff[1] & i_ee_done) begin
            o_ee_req  <= 1'b1;
            o_ee_we   <= 1'b0;
            o_ee_addr <= `PMEA_ADDR_PWD;
         end
         if (~init_ff[3] | ~nxt_powered) begin
            own_ff  <= A_IDLE;
            if (init_ff[3]) begin
               fail_ff <= 3'h0;
               auth_ff <= 1'b0;
            end
         end else begin
            case (own_ff)
               A_IDLE: begin
                  if (i_rf_req & ~silent_block) begin
                     if (i_rf_we & (i_rf_addr == `PMEA_ADDR_PWD) & ~auth_ff) begin
                        if (locked) begin
                           o_rf_nak_prot <= 1'b1;
                        end else if (i_rf_wdata == pwd_ff) begin
                           auth_ff   <= 1'b1;
                           o_rf_done <= 1'b1;
                        end else begin
                           fail_ff       <= fail_ff + 3'h1;
                           o_rf_nak_prot <= 1'b1;
                        end
                     end else if (prot_hit(i_rf_addr, i_rf_we)) begin
                        o_rf_nak_prot <= 1'b1;
                     end else begin
                        own_ff       <= A_RF;
                        own_we_ff    <= i_rf_we;
                        own_addr_ff  <= i_rf_addr;
                        own_wdata_ff <= i_rf_wdata;
                        o_ee_req     <= 1'b1;
                        o_ee_we      <= i_rf_we;
                        o_ee_addr    <= i_rf_addr;
                        o_ee_wdata   <= i_rf_wdata;
                     end
                  end else if (i_sp_req) begin
                     // serial side never sees the password check
                     own_ff       <= A_SP;
                     own_we_ff    <= i_sp_we;
                     own_addr_ff  <= i_sp_addr;
                     own_wdata_ff <= i_sp_wdata;
                     o_ee_req     <= 1'b1;
                     o_ee_we      <= i_sp_we;
                     o_ee_addr    <= i_sp_addr;
                     o_ee_wdata   <= i_sp_wdata;
                  end
               end
               A_RF: begin
                  if (i_sp_req) begin
                     o_irq_err_acc <= 1'b1;
                     o_sp_done     <= 1'b1;
                     o_sp_rdata    <= {DW{1'b0}};
                  end
                  if (i_ee_done) begin
                     own_ff     <= A_IDLE;
                     o_rf_done  <= 1'b1;
                     o_rf_rdata <= own_we_ff ? {DW{1'b0}} : i_ee_rdata;
                  end
               end
               A_SP: begin
                  if (i_rf_req & ~silent_block) begin
                     o_rf_nak_conflict <= 1'b1;
                     o_irq_init        <= 1'b1;
                     o_irq_err_acc     <= 1'b1;
                  end
                  if (i_ee_done) begin
                     own_ff     <= A_IDLE;
                     o_sp_done  <= 1'b1;
                     o_sp_rdata <= own_we_ff ? {DW{1'b0}} : i_ee_rdata;
                  end
               end
               default: begin
                  own_ff <= A_IDLE;
               end
            endcase
         end
      end
   end

   // registered status and power outputs
   always @(posedge i_clk) begin
      if (i_rst) begin
         o_ready              <= 1'b0;
         o_vdd_on             <= 1'b0;
         o_vdd_from_io        <= 1'b0;
         o_power_mode_setting <= `PMEA_PM_DEF;
         o_harvest_en         <= 1'b0;
         o_harvest_oe_n       <= 1'b1;
         o_harvest_rsel       <= 2'h0;
         o_harvest_mv         <= 13'h0000;
         o_rf_off             <= 1'b0;
         o_auth_ok            <= 1'b0;
         o_auth_locked        <= 1'b0;
      end else begin
         o_ready              <= init_ff[3];
         o_vdd_on             <= nxt_powered;
         o_vdd_from_io        <= nxt_vdd_from_io;
         o_power_mode_setting <= pm_ff;
         // pin left floating when harvesting is off
         o_harvest_en         <= harv_on;
         o_harvest_oe_n       <= ~harv_on;
         o_harvest_rsel       <= harv_on ? cfg_ff[`PMEA_F_RSEL] : 2'h0;
         o_harvest_mv         <= harv_mv(cfg_ff[`PMEA_F_VSEL]);
         o_rf_off             <= silent_block;
         o_auth_ok            <= auth_ff;
         o_auth_locked        <= locked;
      end
   end

endmodule // pmea_core

// file: sim/pmea_checker.sv
// assertion checker for the power mode and eeprom arbiter ports
`timescale 1ns/100ps
module pmea_checker #(
   parameter DW = 32
) (
   input wire          i_clk,
   input wire          i_rst,
   input wire          i_field_power_on_detect,
   input wire          i_io_supply_pin,
   input wire          i_cs_n,
   input wire          i_rf_req,
   input wire          i_ee_done,
   input wire          o_ee_req,
   input wire          o_rf_done,
   input wire          o_rf_nak_conflict,
   input wire          o_rf_nak_prot,
   input wire          o_rf_off,
   input wire          o_sp_done,
   input wire [DW-1:0] o_sp_rdata,
   input wire          o_irq_init,
   input wire          o_irq_err_acc,
   input wire          o_ready,
   input wire [1:0]    o_power_mode_setting,
   input wire          o_harvest_en,
   input wire          o_harvest_oe_n,
   input wire [1:0]    o_harvest_rsel,
   input wire [12:0]   o_harvest_mv
);
   // eeprom access in flight, from grant to completion
   reg busy_ff;
   always @(posedge i_clk) begin
      if (i_rst) busy_ff <= 1'b0;
      else if (o_ee_req) busy_ff <= 1'b1;
      else if (i_ee_done) busy_ff <= 1'b0;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_rf_take;
      i_rf_req && o_ready && !busy_ff && !o_rf_off;
   endsequence
   sequence s_rf_ans;
      o_ee_req || o_rf_done || o_rf_nak_prot;
   endsequence
   sequence s_rf_quiet;
      !(o_rf_done || o_rf_nak_conflict || o_rf_nak_prot);
   endsequence
   grant_first_a: assert property (s_rf_take |=> s_rf_ans)
      else $error("idle rf request not answered");
   grant_hold_a: assert property (busy_ff |-> !o_ee_req)
      else $error("new grant during access");
   done_follow_a: assert property (i_ee_done && busy_ff && o_ready |=> o_rf_done || o_sp_done)
      else $error("access end not reported");
   rf_conflict_a: assert property (o_rf_nak_conflict |-> o_irq_init && o_irq_err_acc)
      else $error("conflict nak without irqs");
   sp_zero_a: assert property (o_irq_err_acc && !o_rf_nak_conflict |-> o_sp_done && o_sp_rdata == 0)
      else $error("rejected serial access not zero");
   silent_drop_a: assert property (o_rf_off && i_rf_req |=> s_rf_quiet [*2])
      else $error("rf answered while silent");
   harvest_mode_a: assert property (o_harvest_en |-> o_power_mode_setting == 2'h0)
      else $error("harvest on outside default mode");
   harvest_pin_a: assert property (o_ready |-> o_harvest_oe_n == !(o_harvest_en && o_harvest_rsel != 2'h0))
      else $error("harvest pin drive wrong");
   mv_range_a: assert property (o_ready && o_harvest_en |-> o_harvest_mv == 13'h0708 ||
      (o_harvest_mv >= 13'h076c && o_harvest_mv <= 13'h1194 && (o_harvest_mv - 13'h076c) % 13'h0064 == 0))
      else $error("harvest voltage off table");
   full_reset_a: assert property ($fell(o_ready) |-> !i_field_power_on_detect && (i_cs_n || !i_io_supply_pin))
      else $error("reset while powered");
endmodule // pmea_checker
bind pmea_core pmea_checker #(.DW(DW)) u_chk (.i_clk, .i_rst, .i_field_power_on_detect, .i_io_supply_pin,
   .i_cs_n, .i_rf_req, .i_ee_done, .o_ee_req, .o_rf_done, .o_rf_nak_conflict, .o_rf_nak_prot, .o_rf_off,
   .o_sp_done, .o_sp_rdata, .o_irq_init, .o_irq_err_acc, .o_ready, .o_power_mode_setting, .o_harvest_en,
   .o_harvest_oe_n, .o_harvest_rsel, .o_harvest_mv);

// file: sim/pmea_ee_model.sv
// behavioural eeprom behind the arbiter
`timescale 1ns/100ps
module pmea_ee_model #(
   parameter LAT = 8,
   parameter [31:0] CFG = 32'h0,
   parameter [31:0] PWD = 32'h0,
   parameter [31:0] D16 = 32'h0
) (
   input wire        i_clk,
   input wire        i_req,
   input wire        i_we,
   input wire [7:0]  i_addr,
   input wire [31:0] i_wdata,
   output reg        o_done = 1'b0,
   output reg [31:0] o_rdata = 32'h0
);
   reg [31:0] mem [0:63];
   reg [7:0]  cnt = 8'h00;
   reg [7:0]  adr;
   reg        wr;
   reg [31:0] dat;
   integer    k;
   initial begin
      for (k = 0; k < 64; k = k + 1) mem[k] = 32'h0;
      mem[4] = CFG;
      mem[5] = PWD;
      mem[16] = D16;
   end
   // data toggles outside done so stale words never look valid
   always @(posedge i_clk) begin
      o_done <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req) begin
         adr <= i_addr;
         wr <= i_we;
         dat <= i_wdata;
         cnt <= LAT;
      end else if (cnt != 8'h00) begin
         cnt <= cnt - 8'h01;
         if (cnt == 8'h01) begin
            o_done <= 1'b1;
            if (wr) mem[adr[5:0]] <= dat;
            else o_rdata <= mem[adr[5:0]];
         end
      end
   end
endmodule // pmea_ee_model

// file: sim/testbench.sv
// self-checking bench of the power mode and eeprom arbiter
`timescale 1ns/100ps
module testbench;
   localparam [31:0] CFG = 32'h8101_5a30;
   localparam [31:0] PWD = 32'h0000_1234;
   localparam [31:0] D16 = 32'h5a5a_0f0f;
   reg         i_clk = 1'b0, i_rst = 1'b1, i_field_power_on_detect = 1'b0, i_io_supply_pin = 1'b0;
   reg         i_cs_n = 1'b1, i_io_below_thr = 1'b1, i_cfg2_wr = 1'b0, i_ev_selected = 1'b0;
   reg         i_rf_req = 1'b0, i_rf_we = 1'b0, i_sp_req = 1'b0, i_sp_we = 1'b0, i_ev_sleep_req = 1'b0;
   reg  [1:0]  i_cfg2_mode = 2'h0;
   reg  [7:0]  i_rf_addr = 8'h00, i_sp_addr = 8'h00;
   reg  [31:0] i_rf_wdata = 32'h0, i_sp_wdata = 32'h0;
   wire        i_ee_done, o_ee_req, o_ee_we, o_rf_done, o_rf_nak_conflict, o_rf_nak_prot, o_rf_off;
   wire        o_sp_done, o_irq_init, o_irq_err_acc, o_irq_wake, o_ready, o_vdd_from_io;
   wire        o_harvest_en, o_harvest_oe_n, o_auth_ok, o_auth_locked, o_vdd_on;
   wire [1:0]  o_power_mode_setting, o_harvest_rsel;
   wire [7:0]  o_ee_addr;
   wire [12:0] o_harvest_mv;
   wire [31:0] i_ee_rdata, o_ee_wdata, o_rf_rdata, o_sp_rdata;
   integer     n_fail = 0, check_count = 0, cyc = 0, n_wake = 0, n_init = 0, n_err = 0, e0, e1;
   reg  [1:0]  rf_ans = 2'h0;
   reg         sp_ans = 1'b0;
   reg  [31:0] rf_dat, sp_dat;
   pmea_core #(.IODD_CYC(20)) dut (.i_clk, .i_rst, .i_field_power_on_detect, .i_io_supply_pin, .i_cs_n,
      .i_io_below_thr, .i_cfg2_wr, .i_cfg2_mode, .i_rf_req, .i_rf_we, .i_rf_addr, .i_rf_wdata, .i_ev_selected,
      .i_ev_sleep_req, .i_sp_req, .i_sp_we, .i_sp_addr, .i_sp_wdata, .i_ee_done, .i_ee_rdata, .o_ee_req,
      .o_ee_we, .o_ee_addr, .o_ee_wdata, .o_rf_done, .o_rf_nak_conflict, .o_rf_nak_prot, .o_rf_rdata, .o_rf_off,
      .o_sp_done, .o_sp_rdata, .o_irq_init, .o_irq_err_acc, .o_irq_wake, .o_ready, .o_vdd_on, .o_vdd_from_io,
      .o_power_mode_setting, .o_harvest_en, .o_harvest_oe_n, .o_harvest_rsel, .o_harvest_mv, .o_auth_ok,
      .o_auth_locked);
   pmea_ee_model #(.CFG(CFG), .PWD(PWD), .D16(D16)) u_ee (.i_clk, .i_req(o_ee_req), .i_we(o_ee_we),
      .i_addr(o_ee_addr), .i_wdata(o_ee_wdata), .o_done(i_ee_done), .o_rdata(i_ee_rdata));
   initial forever #5 i_clk = ~i_clk;
   // one-cycle answers are caught here so no task misses them
   always @(posedge i_clk) begin
      if (o_rf_done) rf_dat = o_rf_rdata;
      if (o_rf_done) rf_ans = 2'h1;
      if (o_rf_nak_conflict) rf_ans = 2'h2;
      if (o_rf_nak_prot) rf_ans = 2'h3;
      if (o_sp_done) sp_dat = o_sp_rdata;
      if (o_sp_done) sp_ans = 1'b1;
      n_wake = n_wake + o_irq_wake;
      n_init = n_init + o_irq_init;
      n_err = n_err + o_irq_err_acc;
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         complete_run;
      end
   end
   task tick;
      begin
         @(posedge i_clk);
         #1;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task rf(input we, input [7:0] a, input [31:0] d);
      begin
         rf_ans = 2'h0;
         {i_rf_we, i_rf_addr, i_rf_wdata, i_rf_req} = {we, a, d, 1'b1};
         tick;
         i_rf_req = 1'b0;
      end
   endtask
   task sp(input we, input [7:0] a, input [31:0] d);
      begin
         sp_ans = 1'b0;
         {i_sp_we, i_sp_addr, i_sp_wdata, i_sp_req} = {we, a, d, 1'b1};
         tick;
         i_sp_req = 1'b0;
      end
   endtask
   task wrf;
      integer k;
      for (k = 0; k < 60 && rf_ans == 2'h0; k = k + 1) tick;
   endtask
   task wsp;
      integer k;
      for (k = 0; k < 60 && !sp_ans; k = k + 1) tick;
   endtask
   task wrdy;
      integer k;
      for (k = 0; k < 200 && o_ready !== 1'b1; k = k + 1) tick;
   endtask
   task cfg2(input [1:0] m);
      begin
         {i_cfg2_mode, i_cfg2_wr} = {m, 1'b1};
         tick;
         i_cfg2_wr = 1'b0;
         repeat (3) tick;
      end
   endtask
   task t_init;
      begin
         i_field_power_on_detect = 1'b1;
         wrdy;
         tick;
         chk(o_ready, 1'b1);
         chk(o_power_mode_setting, 2'h0);
         chk(o_harvest_en, 1'b1);
         chk(o_harvest_oe_n, 1'b0);
         chk(o_harvest_rsel, 2'h2);
         chk(o_harvest_mv, 13'h1194);
         chk(o_rf_off, 1'b1);
         chk(n_wake, 1);
         rf(1'b0, 8'h10, 32'h0);
         repeat (20) tick;
         chk(rf_ans, 2'h0);
         i_io_below_thr = 1'b0;
         repeat (4) tick;
         chk(o_rf_off, 1'b0);
         e0 = n_wake;
         i_ev_selected = 1'b1;
         tick;
         i_ev_selected = 1'b0;
         repeat (3) tick;
         chk(n_wake - e0, 1);
         // sleep event is masked off in the loaded config word
         i_ev_sleep_req = 1'b1;
         tick;
         i_ev_sleep_req = 1'b0;
         repeat (3) tick;
         chk(n_wake - e0, 1);
         $display("init and silent test done");
      end
   endtask
   task t_arb;
      begin
         rf(1'b0, 8'h10, 32'h0);
         wrf;
         chk(rf_dat, D16);
         e0 = n_init;
         e1 = n_err;
         sp(1'b1, 8'h11, 32'h1111_2222);
         repeat (2) tick;
         rf(1'b0, 8'h10, 32'h0);
         wrf;
         chk(rf_ans, 2'h2);
         chk(n_init - e0, 1);
         chk(n_err - e1, 1);
         wsp;
         rf(1'b0, 8'h11, 32'h0);
         repeat (2) tick;
         sp(1'b0, 8'h10, 32'h0);
         wsp;
         chk(sp_dat, 32'h0);
         chk(n_err - e1, 2);
         wrf;
         chk(rf_dat, 32'h1111_2222);
         $display("arbitration test done");
      end
   endtask
   task t_auth;
      integer k;
      begin
         for (k = 0; k < 7; k = k + 1) begin
            if (k == 6) chk(o_auth_locked, 1'b0);
            rf(1'b1, 8'h05, 32'hdead_0000 + k);
            wrf;
            chk(rf_ans, 2'h3);
            tick;
         end
         chk(o_auth_locked, 1'b1);
         rf(1'b1, 8'h05, PWD);
         wrf;
         chk(rf_ans, 2'h3);
         chk(o_auth_ok, 1'b0);
         sp(1'b0, 8'h05, 32'h0);
         wsp;
         chk(sp_dat, PWD);
         $display("password test done");
      end
   endtask
   task t_power;
      begin
         i_field_power_on_detect = 1'b0;
         repeat (10) tick;
         chk(o_ready, 1'b0);
         chk(o_auth_locked, 1'b0);
         {i_io_supply_pin, i_cs_n} = 2'b10;
         wrdy;
         chk(o_vdd_from_io, 1'b1);
         i_cs_n = 1'b1;
         repeat (15) tick;
         chk(o_vdd_from_io, 1'b1);
         repeat (20) tick;
         chk(o_ready, 1'b0);
         i_cs_n = 1'b0;
         wrdy;
         cfg2(2'h3);
         i_cs_n = 1'b1;
         repeat (40) tick;
         chk(o_ready, 1'b1);
         chk(o_vdd_from_io, 1'b1);
         chk(o_power_mode_setting, 2'h3);
         chk({o_harvest_en, o_harvest_oe_n}, 2'b01);
         chk(o_vdd_on, 1'b1);
         sp(1'b0, 8'h10, 32'h0);
         wsp;
         chk(sp_dat, D16);
         cfg2(2'h0);
         repeat (40) tick;
         chk(o_ready, 1'b0);
         chk(o_vdd_on, 1'b0);
         $display("power mode test done");
      end
   endtask
   task t_unlock;
      begin
         i_field_power_on_detect = 1'b1;
         wrdy;
         chk(o_auth_locked, 1'b0);
         rf(1'b0, 8'h20, 32'h0);
         wrf;
         chk(rf_ans, 2'h3);
         rf(1'b1, 8'h05, PWD);
         wrf;
         chk(rf_ans, 2'h1);
         chk(o_auth_ok, 1'b1);
         rf(1'b0, 8'h20, 32'h0);
         wrf;
         chk(rf_ans, 2'h1);
         rf(1'b1, 8'h05, 32'h0000_5678);
         wrf;
         chk(rf_ans, 2'h1);
         sp(1'b0, 8'h05, 32'h0);
         wsp;
         chk(sp_dat, 32'h0000_5678);
         $display("unlock test done");
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_rst = 1'b0;
      tick;
      t_init;
      t_arb;
      t_auth;
      t_power;
      t_unlock;
      complete_run;
   end
endmodule // testbench
